// File: ebi_pkg.sv
package ebi_pkg;
   // timing base
   localparam int CLK_HZ = 10_000_000;
   localparam int TICK_MS = 10;
   localparam int TICK_CYC = CLK_HZ / 1000 * TICK_MS;
   localparam int TICKS_PER_S = 1000 / TICK_MS;
   localparam int DEB_MS = 5;
   localparam int DEB_CYC = CLK_HZ / 1000 * DEB_MS;
   // speed switch timing, in ms and ticks
   localparam int MIN_PULSE_MS = 110;
   localparam int MIN_PULSE_TICKS = (MIN_PULSE_MS + TICK_MS - 1) / TICK_MS;
   localparam int FINE_MS = 600;
   localparam int FINE_TICKS = FINE_MS / TICK_MS;
   // speed request in units of 0.001 %
   localparam int SPD_W = 17;
   localparam int FINE_RATE_MPCT_S = 400;
   localparam int FINE_STEP = FINE_RATE_MPCT_S * TICK_MS / 1000;
   localparam int RAMP_SCALE = 100 * TICK_MS / 1000;
   localparam logic [16:0] SPD_MAX = 17'h186a0;
   localparam logic [16:0] SPD_AUX_RUN = 17'h0c350;
   localparam logic [16:0] SPD_ZERO = 17'h00000;
   // register offsets
   localparam logic [7:0] OFS_CTRL = 8'h00;
   localparam logic [7:0] OFS_RAMP = 8'h04;
   localparam logic [7:0] OFS_CLIM = 8'h08;
   localparam logic [7:0] OFS_STAT = 8'h0c;
   localparam logic [7:0] OFS_SPD = 8'h10;
   // reset values
   localparam logic [7:0] CTRL_RST = 8'h00;
   localparam logic [7:0] RAMP_RST = 8'h0a;
   localparam logic [7:0] CLIM_RST = 8'h0a;
   // control bits
   localparam int CB_LOCAL = 0;
   localparam int CB_PRP = 1;
   localparam int CB_ANALOG = 2;
   localparam int CB_DROOP_SELECT_OUTPUT = 3;
   localparam int CB_ALT_SW = 4;
   localparam int CB_IDLE_SW = 5;
   localparam int CB_SF_SD = 6;
   // switch input indices
   localparam int IN_SKIP = 0;
   localparam int IN_EXT = 1;
   localparam int IN_CLUTCH = 2;
   localparam int IN_BYPASS = 3;
   localparam int IN_RAISE = 4;
   localparam int IN_LOWER = 5;
   localparam int IN_ACK = 6;
   localparam int IN_DROOP = 7;
   localparam int IN_ALT = 8;
   localparam int IN_IDLE = 9;
   localparam int IN_REM = 10;
   localparam int NUM_IN = 11;
   // axi responses
   localparam logic [1:0] RESP_OK = 2'h0;
   localparam logic [1:0] RESP_ERR = 2'h2;
   // engine and clutch states
   typedef enum logic [1:0] {
      ENG_STOP = 2'b00,
      ENG_IDLE = 2'b01,
      ENG_RUN = 2'b10
   } ebi_eng_e;
   typedef enum logic {
      CL_IDLE = 1'b0,
      CL_ENGAGE = 1'b1
   } ebi_cl_e;
endpackage

// File: ebi_debounce.sv
`timescale 1ns/1ps
module ebi_debounce #(
   parameter int W = 11,
   parameter int CNT = 50000
) (
   // clock and reset
   input wire logic i_ref_clk,
   input wire logic i_srst,
   // raw and clean levels
   input wire logic [W-1:0] i_raw,
   output logic [W-1:0] o_level
);
   typedef struct packed {
      logic [W-1:0] s1;
      logic [W-1:0] s2;
      logic [W-1:0] q;
      logic [W-1:0][15:0] cnt;
   } ebi_deb_s;
   ebi_deb_s r;
   ebi_deb_s n;
   always_comb begin
      n = r;
      n.s1 = i_raw;
      n.s2 = r.s1;
      for (int i = 0; i < W; i++) begin
         if (r.s2[i] == r.q[i]) begin
            n.cnt[i] = 16'h0000;
         end else if (r.cnt[i] >= 16'(CNT - 1)) begin
            n.cnt[i] = 16'h0000;
            n.q[i] = r.s2[i];
         end else begin
            n.cnt[i] = r.cnt[i] + 16'h0001;
         end
      end
   end
   always_ff @(posedge i_ref_clk) begin
      if (i_srst) begin
         r <= '0;
      end else begin
         r <= n;
      end
   end
   assign o_level = r.q;
endmodule // ebi_debounce

// File: ebi_top.sv
`timescale 1ns/1ps
module ebi_top #(
   parameter int TICK_CYC = ebi_pkg::TICK_CYC,
   parameter int DEB_CYC = ebi_pkg::DEB_CYC
) (
   // clock and reset
   input wire logic i_ref_clk,
   input wire logic i_srst,
   // axi4-lite slave
   input wire logic [7:0] i_axi_awaddr,
   input wire logic i_axi_awvalid,
   output logic o_axi_awready,
   input wire logic [31:0] i_axi_wdata,
   input wire logic [3:0] i_axi_wstrb,
   input wire logic i_axi_wvalid,
   output logic o_axi_wready,
   output logic [1:0] o_axi_bresp,
   output logic o_axi_bvalid,
   input wire logic i_axi_bready,
   input wire logic [7:0] i_axi_araddr,
   input wire logic i_axi_arvalid,
   output logic o_axi_arready,
   output logic [31:0] o_axi_rdata,
   output logic [1:0] o_axi_rresp,
   output logic o_axi_rvalid,
   input wire logic i_axi_rready,
   // switch contacts
   input wire logic [ebi_pkg::NUM_IN-1:0] i_switch,
   // engine state machine
   input wire logic [1:0] i_eng_state,
   input wire logic i_eng_running,
   input wire logic i_idle_timer_run,
   input wire logic i_fuel_sol_req,
   input wire logic i_stop_sol_req,
   input wire logic i_start_fail,
   input wire logic i_panel_stop,
   input wire logic i_remote_stop,
   input wire logic i_blackout_start,
   input wire logic [ebi_pkg::SPD_W-1:0] i_analog_rpm_demand,
   // protection trips
   input wire logic i_trip_overspeed,
   input wire logic i_trip_estop,
   input wire logic i_trip_ovrd_class,
   input wire logic i_trip_other,
   // engine control outputs
   output logic o_idle_end,
   output logic o_external_control_status_text,
   output logic o_eng_out_en,
   output logic o_fuel_sol,
   output logic o_stop_fail_eval,
   output logic o_stop_sol,
   output logic o_takeover,
   output logic o_takeover_run,
   output logic o_clutch_connect,
   output logic o_clutch_fail,
   output logic o_shutdown,
   output logic o_alarm_log,
   output logic o_red_led,
   output logic o_crank_unlimited,
   output logic o_engine_unit_alarm_ack,
   output logic o_droop_select_output,
   output logic o_alt_speed_select_output,
   output logic o_idle_select_output,
   output logic o_start_cmd,
   output logic o_stop_cmd,
   output logic o_start_warn,
   output logic [ebi_pkg::SPD_W-1:0] o_speed_req
);
   typedef struct packed {
      logic [7:0] ctrl;
      logic [7:0] ramp;
      logic [7:0] clim;
      logic [7:0] aw_a;
      logic aw_h;
      logic [31:0] w_d;
      logic w_s;
      logic w_h;
      logic awr;
      logic wr;
      logic bv;
      logic [1:0] br;
      logic arr;
      logic rv;
      logic [31:0] rd;
      logic [1:0] rr;
      logic [ebi_pkg::NUM_IN-1:0] prev;
      logic [1:0] eng_prev;
      logic [16:0] tick;
      logic [6:0] sec;
      logic [5:0] held;
      logic [1:0] dir;
      logic stepped;
      logic [16:0] spd;
      ebi_pkg::ebi_cl_e cl;
      logic [7:0] ccnt;
      logic cfail;
      logic sblock;
      logic [21:0] o;
   } ebi_top_s;

   localparam ebi_top_s RST_S = '{ctrl: ebi_pkg::CTRL_RST, ramp: ebi_pkg::RAMP_RST,
      clim: ebi_pkg::CLIM_RST, cl: ebi_pkg::CL_IDLE, default: '0};

   ebi_top_s r;
   ebi_top_s n;
   logic [ebi_pkg::NUM_IN-1:0] sw;

   ebi_debounce #(
      .W(ebi_pkg::NUM_IN),
      .CNT(DEB_CYC)
   ) u_deb (
      .i_ref_clk(i_ref_clk),
      .i_srst(i_srst),
      .i_raw(i_switch),
      .o_level(sw)
   );

   always_comb begin
      logic ext;
      logic local_control_mode;
      logic tk;
      logic act;
      logic [1:0] d;
      logic [16:0] st;
      logic rem;
      ext = sw[ebi_pkg::IN_EXT];
      local_control_mode = r.ctrl[ebi_pkg::CB_LOCAL];
      rem = sw[ebi_pkg::IN_REM];
      tk = 1'b0;
      act = 1'b0;
      d = 2'b00;
      st = 17'h00000;
      n = r;
      n.prev = sw;
      n.eng_prev = i_eng_state;
      // axi write channel
      if (i_axi_awvalid && r.awr) begin
         n.aw_a = i_axi_awaddr;
         n.aw_h = 1'b1;
      end
      if (i_axi_wvalid && r.wr) begin
         n.w_d = i_axi_wdata;
         n.w_s = i_axi_wstrb[0];
         n.w_h = 1'b1;
      end
      if (r.bv && i_axi_bready) begin
         n.bv = 1'b0;
      end
      if (r.aw_h && r.w_h && !r.bv) begin
         n.aw_h = 1'b0;
         n.w_h = 1'b0;
         n.bv = 1'b1;
         n.br = ebi_pkg::RESP_OK;
         unique case ({r.aw_a[7:2], 2'b00})
            ebi_pkg::OFS_CTRL: if (r.w_s) n.ctrl = {1'b0, r.w_d[6:0]};
            ebi_pkg::OFS_RAMP: if (r.w_s) n.ramp = r.w_d[7:0];
            ebi_pkg::OFS_CLIM: if (r.w_s) n.clim = r.w_d[7:0];
            ebi_pkg::OFS_STAT, ebi_pkg::OFS_SPD: n.br = ebi_pkg::RESP_ERR;
            default: n.br = ebi_pkg::RESP_ERR;
         endcase
      end
      n.awr = !n.aw_h && !n.bv;
      n.wr = !n.w_h && !n.bv;
      // axi read channel
      if (r.rv && i_axi_rready) begin
         n.rv = 1'b0;
      end
      if (i_axi_arvalid && r.arr) begin
         n.rv = 1'b1;
         n.rr = ebi_pkg::RESP_OK;
         n.rd = 32'h00000000;
         unique case ({i_axi_araddr[7:2], 2'b00})
            ebi_pkg::OFS_CTRL: n.rd[7:0] = r.ctrl;
            ebi_pkg::OFS_RAMP: n.rd[7:0] = r.ramp;
            ebi_pkg::OFS_CLIM: n.rd[7:0] = r.clim;
            ebi_pkg::OFS_STAT: n.rd[15:0] = {r.sblock, r.cfail, r.cl == ebi_pkg::CL_ENGAGE,
               2'b00, sw};
            ebi_pkg::OFS_SPD: n.rd[16:0] = r.spd;
            default: n.rr = ebi_pkg::RESP_ERR;
         endcase
      end
      n.arr = !n.rv;
      // time base
      if (r.tick >= 17'(TICK_CYC - 1)) begin
         n.tick = 17'h00000;
         tk = 1'b1;
         n.sec = (r.sec >= 7'(ebi_pkg::TICKS_PER_S - 1)) ? 7'h00 : r.sec + 7'h01;
      end else begin
         n.tick = r.tick + 17'h00001;
      end
      if (sw[ebi_pkg::IN_LOWER]) begin
         d = 2'b10;
      end else if (sw[ebi_pkg::IN_RAISE]) begin
         d = 2'b01;
      end
      act = (d != 2'b00) && local_control_mode && !ext && !r.ctrl[ebi_pkg::CB_ANALOG];
      n.dir = d;
      n.stepped = 1'b0;
      if (!act || d != r.dir) begin
         n.held = 6'h00;
      end else if (tk) begin
         n.held = (r.held == 6'h3f) ? r.held : r.held + 6'h01;
         if (r.held >= 6'(ebi_pkg::MIN_PULSE_TICKS)) begin
            n.stepped = 1'b1;
            if (r.held < 6'(ebi_pkg::FINE_TICKS)) begin
               st = 17'(ebi_pkg::FINE_STEP);
            end else begin
               st = 17'(r.ramp * ebi_pkg::RAMP_SCALE);
            end
            if (d == 2'b10) begin
               n.spd = (r.spd > st) ? r.spd - st : ebi_pkg::SPD_ZERO;
            end else begin
               n.spd = (ebi_pkg::SPD_MAX - r.spd > st) ? r.spd + st : ebi_pkg::SPD_MAX;
            end
         end
      end
      if (r.ctrl[ebi_pkg::CB_ANALOG]) begin
         n.spd = (i_analog_rpm_demand > ebi_pkg::SPD_MAX) ? ebi_pkg::SPD_MAX
            : i_analog_rpm_demand;
      end else if (i_eng_state != r.eng_prev && i_eng_state == ebi_pkg::ENG_IDLE) begin
         n.spd = ebi_pkg::SPD_ZERO;
      end else if (i_eng_state != r.eng_prev && i_eng_state == ebi_pkg::ENG_RUN) begin
         n.spd = r.ctrl[ebi_pkg::CB_PRP] ? ebi_pkg::SPD_ZERO : ebi_pkg::SPD_AUX_RUN;
      end
      unique case (r.cl)
         ebi_pkg::CL_IDLE: begin
            if (sw[ebi_pkg::IN_CLUTCH] && !r.prev[ebi_pkg::IN_CLUTCH] && !ext
               && r.ctrl[ebi_pkg::CB_PRP] && !i_eng_running) begin
               n.cl = ebi_pkg::CL_ENGAGE;
               n.ccnt = 8'h00;
               n.cfail = 1'b0;
            end
         end
         ebi_pkg::CL_ENGAGE: begin
            if (ext || i_eng_running || !r.ctrl[ebi_pkg::CB_PRP]) begin
               n.cl = ebi_pkg::CL_IDLE;
            end else if (r.ccnt >= r.clim) begin
               n.cl = ebi_pkg::CL_IDLE;
               n.cfail = 1'b1;
            end else if (tk && r.sec == 7'h00) begin
               n.ccnt = r.ccnt + 8'h01;
            end
         end
      endcase
      // start fail block, set wins over clear
      if (!rem) begin
         n.sblock = 1'b0;
      end
      if (i_start_fail && r.ctrl[ebi_pkg::CB_SF_SD]) begin
         n.sblock = 1'b1;
      end
      n.o = '0;
      n.o[0] = sw[ebi_pkg::IN_SKIP] && i_idle_timer_run && !ext;
      n.o[1] = ext;
      n.o[2] = !ext;
      n.o[3] = i_fuel_sol_req;
      n.o[4] = !ext;
      n.o[5] = i_stop_sol_req && !ext;
      n.o[6] = !ext && r.prev[ebi_pkg::IN_EXT];
      n.o[7] = n.o[6] ? i_eng_running : r.o[7];
      n.o[8] = (n.cl == ebi_pkg::CL_ENGAGE);
      n.o[9] = n.cfail;
      n.o[10] = i_trip_overspeed || i_trip_estop || i_trip_ovrd_class
         || (i_trip_other && !sw[ebi_pkg::IN_BYPASS]);
      n.o[11] = i_trip_overspeed || i_trip_estop || i_trip_ovrd_class || i_trip_other;
      n.o[12] = n.o[11];
      n.o[13] = sw[ebi_pkg::IN_BYPASS] && i_blackout_start;
      n.o[14] = sw[ebi_pkg::IN_ACK];
      n.o[15] = r.ctrl[ebi_pkg::CB_DROOP_SELECT_OUTPUT] ? sw[ebi_pkg::IN_DROOP] : r.o[15];
      n.o[16] = r.ctrl[ebi_pkg::CB_ALT_SW] ? sw[ebi_pkg::IN_ALT] : r.o[16];
      n.o[17] = r.ctrl[ebi_pkg::CB_IDLE_SW] ? sw[ebi_pkg::IN_IDLE] : r.o[17];
      n.o[18] = !local_control_mode && !ext && rem && (!r.prev[ebi_pkg::IN_REM]
         || (i_start_fail && !n.sblock));
      n.o[19] = !ext && ((!local_control_mode && !rem && r.prev[ebi_pkg::IN_REM])
         || (!rem && (i_panel_stop || i_remote_stop)));
      n.o[20] = i_start_fail;
   end

   always_ff @(posedge i_ref_clk) begin
      if (i_srst) begin
         r <= RST_S;
      end else begin
         r <= n;
      end
   end

   assign o_axi_awready = r.awr;
   assign o_axi_wready = r.wr;
   assign o_axi_bvalid = r.bv;
   assign o_axi_bresp = r.br;
   assign o_axi_arready = r.arr;
   assign o_axi_rvalid = r.rv;
   assign o_axi_rdata = r.rd;
   assign o_axi_rresp = r.rr;
   assign o_idle_end = r.o[0];
   assign o_external_control_status_text = r.o[1];
   assign o_eng_out_en = r.o[2];
   assign o_fuel_sol = r.o[3];
   assign o_stop_fail_eval = r.o[4];
   assign o_stop_sol = r.o[5];
   assign o_takeover = r.o[6];
   assign o_takeover_run = r.o[7];
   assign o_clutch_connect = r.o[8];
   assign o_clutch_fail = r.o[9];
   assign o_shutdown = r.o[10];
   assign o_alarm_log = r.o[11];
   assign o_red_led = r.o[12];
   assign o_crank_unlimited = r.o[13];
   assign o_engine_unit_alarm_ack = r.o[14];
   assign o_droop_select_output = r.o[15];
   assign o_alt_speed_select_output = r.o[16];
   assign o_idle_select_output = r.o[17];
   assign o_start_cmd = r.o[18];
   assign o_stop_cmd = r.o[19];
   assign o_start_warn = r.o[20];
   assign o_speed_req = r.spd;

   default clocking cb @(posedge i_ref_clk);
   endclocking
   default disable iff (i_srst);

   sequence s_ext_release;
      !sw[ebi_pkg::IN_EXT] && r.prev[ebi_pkg::IN_EXT];
   endsequence
   sequence s_both_pressed;
      sw[ebi_pkg::IN_RAISE] && sw[ebi_pkg::IN_LOWER];
   endsequence

   a_idle_skip_end: assert property (
      sw[ebi_pkg::IN_SKIP] && i_idle_timer_run && !sw[ebi_pkg::IN_EXT] |=> o_idle_end)
      else $error("idle not ended by skip input");
   a_ext_status_shown: assert property (
      sw[ebi_pkg::IN_EXT] |=> o_external_control_status_text)
      else $error("external status not shown");
   a_ext_outputs_off: assert property (
      sw[ebi_pkg::IN_EXT] |=> !o_eng_out_en && o_fuel_sol == $past(i_fuel_sol_req))
      else $error("outputs not gated under external control");
   a_stop_sol_block: assert property (
      sw[ebi_pkg::IN_EXT] |=> !o_stop_sol && !o_stop_fail_eval)
      else $error("stop supervision active under external control");
   a_takeover_state: assert property (
      s_ext_release |=> o_takeover && o_takeover_run == $past(i_eng_running))
      else $error("takeover state not captured");
   a_clutch_prp_only: assert property (
      o_clutch_connect |-> $past(r.ctrl[ebi_pkg::CB_PRP]))
      else $error("clutch closed outside propulsion");
   a_bypass_gates_trip: assert property (
      sw[ebi_pkg::IN_BYPASS] && i_trip_other && !i_trip_overspeed && !i_trip_estop
      && !i_trip_ovrd_class |=> !o_shutdown && o_alarm_log)
      else $error("bypass did not inhibit shutdown");
   a_alarm_still_lit: assert property (
      i_trip_overspeed || i_trip_other |=> o_red_led && o_alarm_log)
      else $error("alarm not indicated");
   a_crank_free: assert property (
      sw[ebi_pkg::IN_BYPASS] && i_blackout_start |=> o_crank_unlimited)
      else $error("crank limit not lifted");
   a_lower_wins: assert property (
      s_both_pressed ##1 r.stepped |-> o_speed_req <= $past(o_speed_req))
      else $error("speed rose with both inputs closed");
   a_short_pulse: assert property (
      r.stepped |-> $past(r.held) >= 6'(ebi_pkg::MIN_PULSE_TICKS))
      else $error("speed changed on short pulse");
   a_remote_start: assert property (
      sw[ebi_pkg::IN_REM] && !r.prev[ebi_pkg::IN_REM] && !r.ctrl[ebi_pkg::CB_LOCAL]
      && !sw[ebi_pkg::IN_EXT] |=> o_start_cmd)
      else $error("remote start not issued");
   a_stop_masked: assert property (
      sw[ebi_pkg::IN_REM] && sw[ebi_pkg::IN_REM] == r.prev[ebi_pkg::IN_REM] |=> !o_stop_cmd)
      else $error("stop issued while remote start closed");
endmodule // ebi_top

// File: ebi_eng_model.sv
`timescale 1ns/1ps
module ebi_eng_model #(
   parameter int IDLE_CYC = 3000
) (
   // clock and reset
   input wire logic i_ref_clk,
   input wire logic i_srst,
   // controller commands
   input wire logic i_start_cmd,
   input wire logic i_stop_cmd,
   input wire logic i_idle_end,
   // engine status
   output logic [1:0] o_eng_state,
   output logic o_eng_running,
   output logic o_idle_timer_run
);
   int cnt_ff;
   always @(posedge i_ref_clk) begin
      if (i_srst) begin
         o_eng_state <= ebi_pkg::ENG_STOP;
         cnt_ff <= 0;
      end else if (i_stop_cmd) begin
         o_eng_state <= ebi_pkg::ENG_STOP;
      end else if (i_start_cmd && o_eng_state == ebi_pkg::ENG_STOP) begin
         o_eng_state <= ebi_pkg::ENG_IDLE;
         cnt_ff <= IDLE_CYC;
      end else if (o_eng_state == ebi_pkg::ENG_IDLE) begin
         cnt_ff <= cnt_ff - 1;
         if (i_idle_end || cnt_ff == 1) begin
            o_eng_state <= ebi_pkg::ENG_RUN;
         end
      end
   end
   assign o_eng_running = o_eng_state == ebi_pkg::ENG_RUN;
   assign o_idle_timer_run = o_eng_state == ebi_pkg::ENG_IDLE;
endmodule // ebi_eng_model

// File: tb_top.sv
`timescale 1ns/1ps
module tb_top;
   logic i_ref_clk = 1'h0, i_srst = 1'h1;
   logic [7:0] i_axi_awaddr = 8'h00, i_axi_araddr = 8'h00;
   logic [31:0] i_axi_wdata = 32'h0, o_axi_rdata;
   logic [3:0] i_axi_wstrb = 4'hf;
   logic i_axi_awvalid = 1'h0, i_axi_wvalid = 1'h0, i_axi_arvalid = 1'h0;
   logic i_axi_bready = 1'h1, i_axi_rready = 1'h1;
   logic [10:0] i_switch = 11'h000;
   logic [1:0] i_eng_state, o_axi_bresp, o_axi_rresp;
   logic i_eng_running, i_idle_timer_run;
   logic i_fuel_sol_req = 1'h0, i_stop_sol_req = 1'h0, i_start_fail = 1'h0;
   logic i_panel_stop = 1'h0, i_remote_stop = 1'h0, i_blackout_start = 1'h0;
   logic i_trip_overspeed = 1'h0, i_trip_estop = 1'h0, i_trip_ovrd_class = 1'h0;
   logic i_trip_other = 1'h0;
   logic [16:0] i_analog_rpm_demand = 17'h00000, o_speed_req, last_spd;
   logic o_axi_awready, o_axi_wready, o_axi_bvalid, o_axi_arready, o_axi_rvalid;
   logic o_idle_end, o_external_control_status_text, o_eng_out_en, o_fuel_sol;
   logic o_stop_fail_eval, o_stop_sol, o_takeover, o_takeover_run, o_clutch_connect;
   logic o_clutch_fail, o_shutdown, o_alarm_log, o_red_led, o_crank_unlimited;
   logic o_engine_unit_alarm_ack, o_droop_select_output, o_alt_speed_select_output;
   logic o_idle_select_output, o_start_cmd, o_stop_cmd, o_start_warn;
   int num_errors = 0, n_tests = 0, n_start = 0, n_stop = 0;
   int n_fine = 0, n_ramp = 0, n_bad = 0, n_take = 0, stp_f = 999999, stp_r = 999999, dlt;

   ebi_top #(.TICK_CYC(10), .DEB_CYC(2)) uut (
      .i_ref_clk, .i_srst, .i_axi_awaddr, .i_axi_awvalid, .o_axi_awready, .i_axi_wdata,
      .i_axi_wstrb, .i_axi_wvalid, .o_axi_wready, .o_axi_bresp, .o_axi_bvalid, .i_axi_bready,
      .i_axi_araddr, .i_axi_arvalid, .o_axi_arready, .o_axi_rdata, .o_axi_rresp, .o_axi_rvalid,
      .i_axi_rready, .i_switch, .i_eng_state, .i_eng_running, .i_idle_timer_run,
      .i_fuel_sol_req, .i_stop_sol_req, .i_start_fail, .i_panel_stop, .i_remote_stop,
      .i_blackout_start, .i_analog_rpm_demand, .i_trip_overspeed, .i_trip_estop,
      .i_trip_ovrd_class, .i_trip_other, .o_idle_end, .o_external_control_status_text,
      .o_eng_out_en, .o_fuel_sol, .o_stop_fail_eval, .o_stop_sol, .o_takeover, .o_takeover_run,
      .o_clutch_connect, .o_clutch_fail, .o_shutdown, .o_alarm_log, .o_red_led,
      .o_crank_unlimited, .o_engine_unit_alarm_ack, .o_droop_select_output,
      .o_alt_speed_select_output, .o_idle_select_output, .o_start_cmd, .o_stop_cmd,
      .o_start_warn, .o_speed_req);

   ebi_eng_model eng (.i_ref_clk, .i_srst, .i_start_cmd(o_start_cmd), .i_stop_cmd(o_stop_cmd),
      .i_idle_end(o_idle_end), .o_eng_state(i_eng_state), .o_eng_running(i_eng_running),
      .o_idle_timer_run(i_idle_timer_run));

   always #50 i_ref_clk = ~i_ref_clk;

   // command pulses and speed steps
   always @(posedge i_ref_clk) begin
      n_start += int'(o_start_cmd === 1'h1);
      n_stop += int'(o_stop_cmd === 1'h1);
      n_take += int'(o_takeover === 1'h1);
      dlt = int'(o_speed_req) - int'(last_spd);
      if (dlt == stp_f) n_fine++;
      else if (dlt == stp_r) n_ramp++;
      else if (dlt != 0) n_bad++;
      last_spd <= o_speed_req;
   end

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_tests++;
      if (got !== exp) begin
         num_errors++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task automatic cyc(input int n);
      repeat (n) @(posedge i_ref_clk);
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] rsp);
      i_axi_awaddr <= a;
      i_axi_wdata <= d;
      i_axi_awvalid <= 1'h1;
      i_axi_wvalid <= 1'h1;
      do begin
         @(posedge i_ref_clk);
         if (o_axi_awready) i_axi_awvalid <= 1'h0;
         if (o_axi_wready) i_axi_wvalid <= 1'h0;
      end while (o_axi_bvalid !== 1'h1);
      chk(o_axi_bresp, rsp);
   endtask

   task automatic rd(input logic [7:0] a, input logic [31:0] exp, input logic [1:0] rsp);
      i_axi_araddr <= a;
      i_axi_arvalid <= 1'h1;
      do begin
         @(posedge i_ref_clk);
         if (o_axi_arready) i_axi_arvalid <= 1'h0;
      end while (o_axi_rvalid !== 1'h1);
      chk(o_axi_rdata, exp);
      chk(o_axi_rresp, rsp);
   endtask

   task automatic clr(input int f, input int r);
      n_fine = 0;
      n_ramp = 0;
      n_bad = 0;
      stp_f = f;
      stp_r = r;
   endtask

   task automatic stop_test();
      $display("errors=%0d checks=%0d", num_errors, n_tests);
      if (num_errors == 0 && n_tests > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask

   initial begin
      cyc(20000);
      num_errors++;
      stop_test();
   end

   initial begin
      cyc(3);
      i_srst <= 1'h0;
      rd(ebi_pkg::OFS_CTRL, 32'h0, ebi_pkg::RESP_OK);
      rd(ebi_pkg::OFS_CLIM, 32'h0a, ebi_pkg::RESP_OK);
      rd(ebi_pkg::OFS_RAMP, 32'h0a, ebi_pkg::RESP_OK);
      rd(8'h20, 32'h0, ebi_pkg::RESP_ERR);
      wr(ebi_pkg::OFS_STAT, 32'h1, ebi_pkg::RESP_ERR);
      wr(ebi_pkg::OFS_RAMP, 32'h20, ebi_pkg::RESP_OK);
      wr(ebi_pkg::OFS_CLIM, 32'h01, ebi_pkg::RESP_OK);
      rd(ebi_pkg::OFS_RAMP, 32'h20, ebi_pkg::RESP_OK);
      i_switch[ebi_pkg::IN_REM] <= 1'h1;
      cyc(8);
      chk(n_start, 32'h1);
      chk(i_eng_state, ebi_pkg::ENG_IDLE);
      chk(o_speed_req, ebi_pkg::SPD_ZERO);
      i_start_fail <= 1'h1;
      cyc(1);
      i_start_fail <= 1'h0;
      cyc(1);
      chk(o_start_warn, 32'h1);
      cyc(4);
      chk(n_start, 32'h2);
      wr(ebi_pkg::OFS_CTRL, 32'h40, ebi_pkg::RESP_OK);
      i_start_fail <= 1'h1;
      cyc(1);
      i_start_fail <= 1'h0;
      cyc(4);
      chk(n_start, 32'h2);
      rd(ebi_pkg::OFS_STAT, 32'h8400, ebi_pkg::RESP_OK);
      i_panel_stop <= 1'h1;
      i_remote_stop <= 1'h1;
      cyc(2);
      i_panel_stop <= 1'h0;
      i_remote_stop <= 1'h0;
      cyc(4);
      chk(n_stop, 32'h0);
      i_switch[ebi_pkg::IN_SKIP] <= 1'h1;
      cyc(8);
      i_switch[ebi_pkg::IN_SKIP] <= 1'h0;
      chk(i_eng_state, ebi_pkg::ENG_RUN);
      rd(ebi_pkg::OFS_SPD, ebi_pkg::SPD_AUX_RUN, ebi_pkg::RESP_OK);
      clr(999999, 999999);
      i_switch[ebi_pkg::IN_RAISE] <= 1'h1;
      cyc(200);
      i_switch[ebi_pkg::IN_RAISE] <= 1'h0;
      cyc(8);
      chk(n_bad, 32'h0);
      i_fuel_sol_req <= 1'h1;
      i_stop_sol_req <= 1'h1;
      i_switch[ebi_pkg::IN_EXT] <= 1'h1;
      cyc(8);
      chk({o_external_control_status_text, o_eng_out_en, o_fuel_sol}, 32'h5);
      chk({o_stop_fail_eval, o_stop_sol}, 32'h0);
      i_switch[ebi_pkg::IN_EXT] <= 1'h0;
      i_stop_sol_req <= 1'h0;
      cyc(8);
      chk({o_takeover_run, o_eng_out_en, i_eng_state}, 32'he);
      chk(n_take, 32'h1);
      wr(ebi_pkg::OFS_CTRL, 32'h01, ebi_pkg::RESP_OK);
      i_switch[ebi_pkg::IN_REM] <= 1'h0;
      cyc(8);
      chk(n_stop, 32'h0);
      clr(4, 32);
      i_switch[ebi_pkg::IN_RAISE] <= 1'h1;
      cyc(90);
      i_switch[ebi_pkg::IN_RAISE] <= 1'h0;
      cyc(8);
      chk(n_fine + n_ramp + n_bad, 32'h0);
      i_switch[ebi_pkg::IN_RAISE] <= 1'h1;
      cyc(800);
      i_switch[ebi_pkg::IN_RAISE] <= 1'h0;
      cyc(8);
      chk(n_fine, 32'h31);
      chk({n_bad[7:0], 7'(n_ramp >= 15)}, 32'h1);
      clr(-4, -32);
      i_switch[5:4] <= 2'h3;
      cyc(800);
      i_switch[5:4] <= 2'h0;
      cyc(8);
      chk(n_fine, 32'h31);
      chk({n_bad[7:0], 7'(n_ramp >= 15)}, 32'h1);
      wr(ebi_pkg::OFS_CTRL, 32'h3a, ebi_pkg::RESP_OK);
      i_remote_stop <= 1'h1;
      i_switch[9:7] <= 3'h7;
      cyc(8);
      i_remote_stop <= 1'h0;
      chk(i_eng_state, ebi_pkg::ENG_STOP);
      chk({o_droop_select_output, o_alt_speed_select_output, o_idle_select_output}, 32'h7);
      wr(ebi_pkg::OFS_CTRL, 32'h02, ebi_pkg::RESP_OK);
      i_switch[9:7] <= 3'h0;
      cyc(8);
      chk({o_droop_select_output, o_alt_speed_select_output, o_idle_select_output}, 32'h7);
      i_switch[ebi_pkg::IN_REM] <= 1'h1;
      cyc(8);
      i_switch[ebi_pkg::IN_SKIP] <= 1'h1;
      cyc(8);
      i_switch[ebi_pkg::IN_SKIP] <= 1'h0;
      chk({i_eng_state, o_speed_req}, {ebi_pkg::ENG_RUN, ebi_pkg::SPD_ZERO});
      i_switch[ebi_pkg::IN_REM] <= 1'h0;
      cyc(8);
      chk(i_eng_state, ebi_pkg::ENG_STOP);
      i_switch[ebi_pkg::IN_CLUTCH] <= 1'h1;
      i_switch[ebi_pkg::IN_ACK] <= 1'h1;
      cyc(8);
      chk({o_clutch_connect, o_engine_unit_alarm_ack}, 32'h3);
      cyc(1200);
      chk(o_clutch_fail, 32'h1);
      rd(ebi_pkg::OFS_STAT, 32'h4044, ebi_pkg::RESP_OK);
      i_switch[ebi_pkg::IN_BYPASS] <= 1'h1;
      i_blackout_start <= 1'h1;
      i_trip_other <= 1'h1;
      cyc(8);
      chk({o_shutdown, o_alarm_log, o_red_led, o_crank_unlimited}, 32'h7);
      i_trip_overspeed <= 1'h1;
      cyc(4);
      chk(o_shutdown, 32'h1);
      wr(ebi_pkg::OFS_CTRL, 32'h04, ebi_pkg::RESP_OK);
      i_analog_rpm_demand <= 17'h1e240;
      cyc(2);
      chk(o_speed_req, ebi_pkg::SPD_MAX);
      i_analog_rpm_demand <= 17'h03039;
      cyc(2);
      chk(o_speed_req, 32'h3039);
      stop_test();
   end
endmodule // tb_top
